// [hw/gfm_mapper.v]
`timescale 1ns/100ps
`include "gfm_consts.vh"

module gfm_mapper #(
	parameter CH = 4
) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`GFM_AW-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// multifunction pin
	input wire pin_in,
	output reg pin_out,
	output reg pin_oe,
	// status sources
	input wire nvm_write_pending,
	input wire [CH-1:0] converter_busy,
	input wire [CH-1:0] window_compare_result,
	// device actions
	output reg deep_sleep,
	output reg [CH-1:0] iout_powerdown,
	output reg [CH-1:0] vout_powerdown,
	output reg [2*CH-1:0] voltage_powerdown_setting,
	output reg [CH-1:0] func_gen_run,
	output reg [CH-1:0] margin_low_strobe,
	output reg [CH-1:0] margin_high_strobe,
	output reg [CH-1:0] load_outputs_strobe,
	output reg protect_strobe,
	output reg clear_outputs_strobe,
	output reg fault_dump_strobe,
	output reg device_reset_strobe,
	output reg nvm_prog_allowed,
	output reg reg_write_allowed
);
	reg [`GFM_CFG_W-1:0] cfg;
	reg [`GFM_CFG_W-1:0] nv_cfg;
	reg [CH-1:0] sync_cfg;
	reg reset_armed;
	reg [31:0] next_rdata;
	reg next_err;

	wire pin_level;
	wire pin_rise;
	wire pin_fall;

	gfm_pin_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in(pin_in),
		.level(pin_level),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	wire gpi = cfg[`GFM_CFG_IEN];
	wire [3:0] code = cfg[`GFM_CFG_CODE];
	wire [CH-1:0] chm = cfg[`GFM_CFG_CHM];
	wire [3:0] osel = cfg[`GFM_CFG_OSEL];
	wire fe = gpi & pin_fall;
	wire re = gpi & pin_rise;

	wire sel_protect = gpi & (code == `GFM_C_PROTECT);
	wire sel_clear = gpi & (code == `GFM_C_CLEAR);
	wire sel_load = gpi & (code == `GFM_C_LOAD);
	wire sel_fdump = gpi & (code == `GFM_C_FDUMP);
	wire sel_reset = gpi & (code == `GFM_C_RESET);

	// a reset mapping only counts when the nonvolatile copy carries it too
	wire nv_reset_ok = nv_cfg[`GFM_CFG_IEN] & (nv_cfg[`GFM_CFG_CODE] == `GFM_C_RESET);
	wire reset_fire = sel_reset & nv_reset_ok & pin_rise & reset_armed;

	// apb: one wait state, every access completes on the edge pready is high
	wire apb_setup = psel & penable & ~pready;
	wire apb_done = psel & penable & pready;
	wire is_unlock = (paddr == `GFM_OFS_UNLOCK);
	wire wr_ok = apb_done & pwrite & (reg_write_allowed | is_unlock);
	wire sw_wr = wr_ok & (paddr == `GFM_OFS_SWTRIG);
	wire [31:0] swd = sw_wr ? pwdata : 32'h00000000;

	// software triggers are dropped while the pin owns the same action
	wire sw_protect = swd[`GFM_SW_PROTECT] & ~sel_protect;
	wire sw_clear = swd[`GFM_SW_CLEAR] & ~sel_clear;
	wire sw_load = swd[`GFM_SW_LOAD] & ~sel_load;
	wire sw_fdump = swd[`GFM_SW_FDUMP] & ~sel_fdump;
	wire sw_reset = swd[`GFM_SW_RESET] & ~sel_reset;
	wire dev_rst = reset_fire | sw_reset;

	always @* begin
		next_rdata = 32'h00000000;
		next_err = 1'b0;
		case (paddr)
			`GFM_OFS_CFG: next_rdata[`GFM_CFG_W-1:0] = cfg;
			`GFM_OFS_NVCFG: next_rdata[`GFM_CFG_W-1:0] = nv_cfg;
			`GFM_OFS_SWTRIG: next_rdata = 32'h00000000;
			`GFM_OFS_STATUS: next_rdata = {{(28-3*CH){1'b0}}, pin_level, reg_write_allowed,
				nvm_prog_allowed, deep_sleep, func_gen_run, vout_powerdown,
				iout_powerdown};
			`GFM_OFS_SYNC: next_rdata[CH-1:0] = sync_cfg;
			`GFM_OFS_VPD: next_rdata[2*CH-1:0] = voltage_powerdown_setting;
			`GFM_OFS_UNLOCK: next_rdata = 32'h00000000;
			default: next_err = 1'b1;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready <= apb_setup;
			if (apb_setup) begin
				prdata <= pwrite ? 32'h00000000 : next_rdata;
				pslverr <= next_err;
			end else begin
				prdata <= 32'h00000000;
				pslverr <= 1'b0;
			end
		end
	end

	// nonvolatile copy: only power-on reset clears it, device reset keeps it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nv_cfg <= `GFM_CFG_RST;
		end else if (wr_ok & (paddr == `GFM_OFS_NVCFG) & nvm_prog_allowed) begin
			nv_cfg <= pwdata[`GFM_CFG_W-1:0];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg <= `GFM_CFG_RST;
			sync_cfg <= {CH{1'b0}};
			voltage_powerdown_setting <= {2*CH{1'b0}};
			reset_armed <= 1'b0;
			deep_sleep <= 1'b0;
			iout_powerdown <= {CH{1'b0}};
			vout_powerdown <= {CH{1'b0}};
			func_gen_run <= {CH{1'b0}};
			margin_low_strobe <= {CH{1'b0}};
			margin_high_strobe <= {CH{1'b0}};
			load_outputs_strobe <= {CH{1'b0}};
			protect_strobe <= 1'b0;
			clear_outputs_strobe <= 1'b0;
			fault_dump_strobe <= 1'b0;
			device_reset_strobe <= 1'b0;
			nvm_prog_allowed <= 1'b1;
			reg_write_allowed <= 1'b1;
			pin_out <= 1'b0;
			pin_oe <= 1'b0;
		end else begin
			// strobes default low (device_reset_strobe follows dev_rst) so each edge gives one cycle only
			margin_low_strobe <= {CH{1'b0}};
			margin_high_strobe <= {CH{1'b0}};
			load_outputs_strobe <= {CH{1'b0}};
			protect_strobe <= 1'b0;
			clear_outputs_strobe <= 1'b0;
			fault_dump_strobe <= 1'b0;
			device_reset_strobe <= dev_rst;
			pin_oe <= cfg[`GFM_CFG_OEN] & ~gpi;
			case (osel[3:2])
				2'b00: pin_out <= (osel == `GFM_O_NVM) & nvm_write_pending;
				`GFM_O_BUSY: pin_out <= converter_busy[osel[1:0]];
				`GFM_O_WIN: pin_out <= window_compare_result[osel[1:0]];
				default: pin_out <= 1'b0;
			endcase
			if (dev_rst) begin
				// volatile state lost; mapping comes back from the nonvolatile copy
				cfg <= nv_cfg;
				sync_cfg <= {CH{1'b0}};
				voltage_powerdown_setting <= {2*CH{1'b0}};
				reset_armed <= 1'b0;
				deep_sleep <= 1'b0;
				iout_powerdown <= {CH{1'b0}};
				vout_powerdown <= {CH{1'b0}};
				func_gen_run <= {CH{1'b0}};
				nvm_prog_allowed <= 1'b1;
				reg_write_allowed <= 1'b1;
			end else begin
				if (wr_ok & (paddr == `GFM_OFS_CFG))
					cfg <= pwdata[`GFM_CFG_W-1:0];
				if (wr_ok & (paddr == `GFM_OFS_SYNC))
					sync_cfg <= pwdata[CH-1:0];
				if (wr_ok & (paddr == `GFM_OFS_VPD))
					voltage_powerdown_setting <= pwdata[2*CH-1:0];
				if (sel_reset & pin_fall)
					reset_armed <= 1'b1;
				else if (~sel_reset | pin_rise)
					reset_armed <= 1'b0;
				protect_strobe <= sw_protect | (sel_protect & pin_fall);
				clear_outputs_strobe <= sw_clear | (sel_clear & pin_fall);
				fault_dump_strobe <= sw_fdump | (sel_fdump & pin_fall);
				if (sw_load)
					load_outputs_strobe <= sync_cfg;
				else if (sel_load & pin_fall)
					load_outputs_strobe <= chm & sync_cfg;
				case (code)
					`GFM_C_SLEEP: begin
						if (fe)
							deep_sleep <= 1'b1;
						else if (re)
							deep_sleep <= 1'b0;
					end
					`GFM_C_IOUT: begin
						if (fe)
							iout_powerdown <= iout_powerdown | chm;
						else if (re)
							iout_powerdown <= iout_powerdown & ~chm;
					end
					`GFM_C_VOUT: begin
						if (fe)
							vout_powerdown <= vout_powerdown | chm;
						else if (re)
							vout_powerdown <= vout_powerdown & ~chm;
					end
					`GFM_C_FGEN: begin
						if (re)
							func_gen_run <= func_gen_run | chm;
						else if (fe)
							func_gen_run <= func_gen_run & ~chm;
					end
					`GFM_C_MARGIN: begin
						if (fe)
							margin_low_strobe <= chm;
						else if (re)
							margin_high_strobe <= chm;
					end
					`GFM_C_NVLOCK: begin
						if (fe)
							nvm_prog_allowed <= 1'b1;
						else if (re)
							nvm_prog_allowed <= 1'b0;
					end
					`GFM_C_WRLOCK: begin
						if (fe)
							reg_write_allowed <= 1'b1;
						else if (re)
							reg_write_allowed <= 1'b0;
					end
					default: begin
					end
				endcase
				// the key can lift a pin lock; a pin edge in the same cycle wins
				if (wr_ok & is_unlock & ~(fe | re) &
					(pwdata[`GFM_KEY_BITS] == `GFM_UNLOCK_KEY))
					reg_write_allowed <= 1'b1;
			end
		end
	end
endmodule

// [hw/gfm_consts.vh]
`ifndef GFM_CONSTS_VH
`define GFM_CONSTS_VH

// apb
`define GFM_AW 8
`define GFM_OFS_CFG 8'h00
`define GFM_OFS_NVCFG 8'h04
`define GFM_OFS_SWTRIG 8'h08
`define GFM_OFS_STATUS 8'h0c
`define GFM_OFS_SYNC 8'h10
`define GFM_OFS_VPD 8'h14
`define GFM_OFS_UNLOCK 8'h18

// pin configuration word, used by both volatile and nonvolatile copies
`define GFM_CFG_W 14
`define GFM_CFG_IEN 0
`define GFM_CFG_CODE 4:1
`define GFM_CFG_CHM 8:5
`define GFM_CFG_OSEL 12:9
`define GFM_CFG_OEN 13
`define GFM_CFG_RST 14'h0000

// software trigger bits
`define GFM_SW_PROTECT 0
`define GFM_SW_CLEAR 1
`define GFM_SW_LOAD 2
`define GFM_SW_FDUMP 3
`define GFM_SW_RESET 4

// input function codes
`define GFM_C_SLEEP 4'h0
`define GFM_C_FDUMP 4'h2
`define GFM_C_IOUT 4'h3
`define GFM_C_VOUT 4'h4
`define GFM_C_PROTECT 4'h5
`define GFM_C_CLEAR 4'h7
`define GFM_C_LOAD 4'h8
`define GFM_C_FGEN 4'h9
`define GFM_C_MARGIN 4'ha
`define GFM_C_RESET 4'hb
`define GFM_C_NVLOCK 4'hc
`define GFM_C_WRLOCK 4'hd

// output status select codes
`define GFM_O_NVM 4'h1
`define GFM_O_BUSY 2'b01
`define GFM_O_WIN 2'b10

// misc
`define GFM_UNLOCK_KEY 4'ha
`define GFM_KEY_BITS 3:0
`define GFM_PIN_IDLE 1'b1

`endif

// [hw/gfm_pin_sync.v]
`timescale 1ns/100ps
`include "gfm_consts.vh"

module gfm_pin_sync (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// pin side
	input wire pin_in,
	// synchronised view
	output wire level,
	output wire rise,
	output wire fall
);
	reg meta;
	reg stable;
	reg prev;

	// meta feeds only stable; edges are judged from stable and prev
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= `GFM_PIN_IDLE;
			stable <= `GFM_PIN_IDLE;
			prev <= `GFM_PIN_IDLE;
		end else begin
			meta <= pin_in;
			stable <= meta;
			prev <= stable;
		end
	end

	assign level = stable;
	assign rise = stable & ~prev;
	assign fall = ~stable & prev;
endmodule

// [test/gfm_mapper_asserts.sv]
`timescale 1ns/100ps
module gfm_mapper_chk #(
	parameter CH = 4
) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// watched ports
	input wire pready,
	input wire pslverr,
	input wire pin_in,
	input wire deep_sleep,
	input wire [CH-1:0] iout_powerdown,
	input wire clear_outputs_strobe,
	input wire device_reset_strobe,
	input wire nvm_prog_allowed,
	input wire reg_write_allowed
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// pin actions land three edges after the pin is sampled
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	clear_single_a: assert property (clear_outputs_strobe |=> !clear_outputs_strobe)
		else $error("clear strobe too long");
	clear_cause_a: assert property (clear_outputs_strobe |-> !$past(pin_in, 3))
		else $error("clear without pin fall");
	sleep_cause_a: assert property ($rose(deep_sleep) |-> !$past(pin_in, 3))
		else $error("sleep without pin fall");
	reset_cause_a: assert property (device_reset_strobe |-> $past(pin_in, 3))
		else $error("reset without pin rise");
	iout_cause_a: assert property ($rose(iout_powerdown[0]) |-> !$past(pin_in, 3))
		else $error("powerdown without pin fall");
	wrlock_cause_a: assert property ($fell(reg_write_allowed) |-> $past(pin_in, 3))
		else $error("write lock without pin rise");
	nvlock_cause_a: assert property ($fell(nvm_prog_allowed) |-> $past(pin_in, 3))
		else $error("nvm lock without pin rise");
endmodule
bind gfm_mapper gfm_mapper_chk #(.CH(CH)) u_gfm_mapper_chk (.pclk(pclk), .presetn(presetn),
	.pready(pready), .pslverr(pslverr), .pin_in(pin_in), .deep_sleep(deep_sleep),
	.iout_powerdown(iout_powerdown), .clear_outputs_strobe(clear_outputs_strobe),
	.device_reset_strobe(device_reset_strobe), .nvm_prog_allowed(nvm_prog_allowed),
	.reg_write_allowed(reg_write_allowed));

// [test/gfm_pin_host.sv]
`timescale 1ns/100ps
module gfm_pin_host (
	// clock
	input wire pclk,
	// pin drive
	output reg drv
);
	// never floats: starts at the idle level
	initial drv = 1'b1;
	task drive(input v);
		begin
			@(posedge pclk);
			drv <= v;
		end
	endtask
endmodule

// [test/tb_top.sv]
`timescale 1ns/100ps
`include "gfm_consts.vh"
module tb_top;
	reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, nwp = 1;
	reg [7:0] paddr = 0;
	reg [31:0] pwdata = 0, r;
	reg [3:0] cb = 4'h1, wc = 4'h4, ld = 4'h0, ml = 4'h0, mh = 4'h0;
	wire [31:0] prdata;
	wire pready, pslverr, pin_out, pin_oe, drv, ds, cs, ps, rs, na, wa, fd;
	wire [3:0] iop, fg, ls, vop, mlo, mhi;
	wire [7:0] vps;
	integer miscompares = 0, compares = 0, cnt = 0, rc = 0, fdc = 0, i, j;
	reg e;
	wire pin_w = pin_oe ? pin_out : drv;
	initial forever #5 pclk = ~pclk;
	gfm_pin_host u_gfm_pin_host (.pclk(pclk), .drv(drv));
	gfm_mapper u_gfm_mapper (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_in(pin_w), .pin_out(pin_out), .pin_oe(pin_oe),
		.nvm_write_pending(nwp), .converter_busy(cb), .window_compare_result(wc),
		.deep_sleep(ds), .iout_powerdown(iop), .vout_powerdown(vop),
		.voltage_powerdown_setting(vps), .func_gen_run(fg), .margin_low_strobe(mlo),
		.margin_high_strobe(mhi), .load_outputs_strobe(ls), .protect_strobe(ps),
		.clear_outputs_strobe(cs), .fault_dump_strobe(fd), .device_reset_strobe(rs),
		.nvm_prog_allowed(na), .reg_write_allowed(wa));
	// outputs are unknown until the first reset edge, so count only out of reset
	always @(posedge pclk) begin
		if (presetn) begin
			cnt <= cnt + cs + ps;
			rc <= rc + rs;
			fdc <= fdc + fd;
			ld <= ld | ls;
			ml <= ml | mlo;
			mh <= mh | mhi;
		end
	end
	task summarize;
		begin
			$display("checks %0d mismatches %0d", compares, miscompares);
			if (miscompares == 0 && compares > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	task chk(input [31:0] x, input [31:0] g, input [127:0] nm);
		begin
			compares = compares + 1;
			if (g !== x) begin
				miscompares = miscompares + 1;
				$display("mismatch %0s exp %h got %h", nm, x, g);
			end
		end
	endtask
	task apb(input w, input [7:0] a, input [31:0] d);
		integer n;
		begin
			@(posedge pclk);
			psel <= 1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1;
			n = 0;
			do begin
				@(posedge pclk);
				n = n + 1;
			end while (pready !== 1'b1 && n < 20);
			r = prdata;
			e = pslverr;
			psel <= 0;
			penable <= 0;
			if (n >= 20) begin
				miscompares = miscompares + 1;
				summarize;
			end
			// a write lands on the ready edge; let it settle before outputs are read
			@(posedge pclk);
		end
	endtask
	task rd(input [7:0] a, input [31:0] x);
		begin
			apb(0, a, 0);
			chk(x, r, "prdata");
		end
	endtask
	task pin(input v);
		begin
			u_gfm_pin_host.drive(v);
			repeat (6) @(posedge pclk);
		end
	endtask
	function [31:0] cfg(input [3:0] c, input [3:0] m);
		cfg = {23'h0, m, c, 1'b1};
	endfunction
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1;
		rd(`GFM_OFS_STATUS, 32'h0000e000);
		apb(0, 8'h1c, 0);
		chk(1, e, "pslverr");
		apb(1, `GFM_OFS_CFG, cfg(4'h0, 0));
		pin(0);
		chk(1, ds, "sleep");
		pin(1);
		chk(0, ds, "sleep");
		apb(1, `GFM_OFS_CFG, cfg(4'h3, 4'h5));
		pin(0);
		chk(4'h5, iop, "iout");
		pin(1);
		chk(0, iop, "iout");
		apb(1, `GFM_OFS_CFG, cfg(4'h9, 4'ha));
		pin(0);
		pin(1);
		chk(4'ha, fg, "gen");
		apb(1, `GFM_OFS_CFG, cfg(4'h4, 4'h6));
		pin(0);
		chk(4'h6, vop, "vout");
		pin(1);
		chk(0, vop, "vout");
		apb(1, `GFM_OFS_CFG, cfg(4'ha, 4'h9));
		pin(0);
		chk(4'h9, ml, "margin_lo");
		chk(0, mh, "margin_hi");
		pin(1);
		chk(4'h9, mh, "margin_hi");
		apb(1, `GFM_OFS_CFG, cfg(4'h2, 0));
		pin(0);
		pin(1);
		chk(1, fdc, "fault_dump");
		for (i = 5; i < 8; i = i + 2) begin
			apb(1, `GFM_OFS_CFG, cfg(i, 0));
			pin(0);
			pin(1);
		end
		apb(1, `GFM_OFS_SWTRIG, 32'h2);
		repeat (4) @(posedge pclk);
		chk(2, cnt, "strobes");
		$display("pin input tests done");
		apb(1, `GFM_OFS_CFG, cfg(4'hd, 0));
		pin(0);
		pin(1);
		chk(0, wa, "wr_allow");
		apb(1, `GFM_OFS_SYNC, 32'hf);
		rd(`GFM_OFS_SYNC, 0);
		apb(1, `GFM_OFS_UNLOCK, 32'ha);
		chk(1, wa, "wr_allow");
		apb(1, `GFM_OFS_CFG, cfg(4'hc, 0));
		pin(0);
		pin(1);
		chk(0, na, "nvm_allow");
		apb(1, `GFM_OFS_NVCFG, 32'h17);
		rd(`GFM_OFS_NVCFG, 0);
		pin(0);
		apb(1, `GFM_OFS_NVCFG, 32'h17);
		pin(1);
		apb(1, `GFM_OFS_VPD, 32'ha5);
		chk(8'ha5, vps, "vpd");
		apb(1, `GFM_OFS_CFG, 32'h17);
		pin(0);
		chk(0, rc, "reset");
		pin(1);
		chk(1, rc, "reset");
		rd(`GFM_OFS_CFG, 32'h17);
		chk(0, vps, "vpd");
		$display("lock and reset tests done");
		apb(1, `GFM_OFS_CFG, cfg(4'h8, 4'h3));
		apb(1, `GFM_OFS_SYNC, 32'h6);
		ld <= 0;
		pin(0);
		pin(1);
		chk(4'h2, ld, "load");
		for (i = 0; i < 5; i = i + 1) begin
			j = i * 3 + 1;
			apb(1, `GFM_OFS_CFG, {18'h0, 1'b1, j[3:0], 9'h0});
			repeat (4) @(posedge pclk);
			chk(1, pin_oe, "pin_oe");
			chk(i < 4 ? i != 2 : 0, pin_out, "pin_out");
		end
		$display("output tests done");
		summarize;
	end
endmodule
